// ### hw/ccp_regs.vh
`ifndef CCP_REGS_VH
`define CCP_REGS_VH

// register byte offsets
`define CCP_CTRL      8'h00
`define CCP_INDEX     8'h04
`define CCP_WIDTH     8'h08
`define CCP_OFFSET    8'h0c
`define CCP_STATUS    8'h10
`define CCP_ENT_ADDR  8'h14
`define CCP_ENT_DATA  8'h18
`define CCP_AXIS_SEL  8'h1c
`define CCP_CYCLE     8'h20
`define CCP_ENG_POS   8'h24
`define CCP_DIS_POS   8'h28
`define CCP_CON_AXES  8'h2c
`define CCP_CON_EXP   8'h30
`define CCP_CON_STAT  8'h34
`define CCP_MPOS      8'h38
`define CCP_INC_BASE  8'h40

// control field positions
`define CCP_CTRL_EN   0
`define CCP_MSEL_LSB  4

// sizes and limits
`define CCP_AXES      8
`define CCP_LAST_IDX  9'h100
`define CCP_EXP_MAX   4'h8

// reset values
`define CCP_WIDTH_RST 32'h0000_0001
`define CCP_ZERO32    32'h0000_0000

// timing: update tick
`define CCP_TICK_US   1000
`define CCP_CLK_MHZ   200

`endif

// ### hw/ccp_table_ram.v
`timescale 1ns/1ps
// cam table storage: one write port, registered read data
module ccp_table_ram (
    input  wire        i_mclk,
    input  wire        i_we,
    input  wire        i_re,
    input  wire [11:0] i_addr,
    input  wire [31:0] i_wdata,
    output reg  [31:0] o_rdata
);
    reg [31:0] mem [0:4095];   // {point index, axis} words

    // read data only moves on a read, so a bus read survives the fsm
    always @(posedge i_mclk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        if (i_re) begin
            o_rdata <= mem[i_addr];
        end
    end
endmodule

// ### hw/ccp_profiler.v
// Functional notes
// - host picks master axis; its encoder feeds cam
// - cam enable bit, readable back
// - host write sets cam table index
// - host reads current cam table index
// - per-axis cycle change stored and readable
// - interval width and offset place table points
// - interval width readable
// - indexed table entries hold slave positions
// - disengage slave at chosen master position
// - engage status readable per axis
// - contour on any one to eight axes
// - unselected axes untouched by contour
// - segment lasts two to the n ms
// - one increment per selected axis per segment
// - linear interpolation, one point per ms
// - zero exponent then zero increment exits
// - no pending segment: wait, no new points
// - next segment held until interval elapses
// - master modulo cycle, rezeroed at cycle end
//
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "ccp_regs.vh"
module ccp_profiler #(
    parameter TICK_CYCLES = `CCP_TICK_US * `CCP_CLK_MHZ
) (
    input  wire         i_mclk,
    input  wire         i_rst,
    input  wire [7:0]   i_avs_address,
    input  wire         i_avs_read,
    input  wire         i_avs_write,
    input  wire [31:0]  i_avs_writedata,
    input  wire [3:0]   i_avs_byteenable,
    output reg  [31:0]  o_avs_readdata,
    output reg          o_avs_waitrequest,
    input  wire [255:0] i_enc_pos,
    output wire [255:0] o_cmd_pos,
    output wire [7:0]   o_cmd_valid,
    output wire [7:0]   o_cam_engage_status
);
    localparam S_IDLE = 3'h0;
    localparam S_MOD  = 3'h1;
    localparam S_SEEK = 3'h2;
    localparam S_RD0  = 3'h3;
    localparam S_RD1  = 3'h4;
    localparam S_RD2  = 3'h5;

    ////////////////////////////////////////////////////////////////////
    // state
    reg  [31:0] tick_cnt;          // millisecond divider
    reg         tick;              // one-cycle ms enable
    reg         tick_pend;         // cam pass owed
    reg  [2:0]  st;                // cam fsm state
    reg  [2:0]  ax;                // axis under interpolation
    reg         cam_enable;        // cam mode on
    reg  [2:0]  cam_master_select; // master axis
    reg  [8:0]  idx;               // cam table index counter
    reg  [31:0] width;             // master counts per interval
    reg  [31:0] offset;            // master position of point 0
    reg  [31:0] seg;               // master position of point idx
    reg  [31:0] mbase;             // encoder value at cycle zero
    reg  [31:0] mpos;              // master position within cycle
    reg  [31:0] mprev;             // master position one pass ago
    reg         chk;               // engage check pulse
    reg  [31:0] t0;                // table value at left point
    reg  [11:0] ent_addr;          // host table pointer
    reg  [2:0]  asel;              // host axis pointer
    reg  [7:0]  con_sel;           // contour axes
    reg  [3:0]  con_exp;           // exponent for next segment
    reg  [3:0]  exp_cur;           // exponent of running segment
    reg         con_act;           // contour mode active
    reg         con_run;           // a segment is being stepped
    reg  [8:0]  k;                 // ms steps done in segment
    reg         mrd_pend;          // bus table read in flight
    wire [31:0] mem_q;             // table read data
    wire [31:0] cyc_w  [0:7];      // per-axis cycle change
    wire [31:0] epos_w [0:7];      // per-axis engage position
    wire [31:0] dpos_w [0:7];      // per-axis disengage position
    wire [15:0] inc_w  [0:7];      // per-axis pending increment
    wire [7:0]  pend;              // increment waiting per axis
    wire [7:0]  dis_arm;           // disengage armed per axis

    ////////////////////////////////////////////////////////////////////
    // bus decode
    wire [7:0]  a      = i_avs_address;
    wire        req    = (i_avs_read | i_avs_write) & o_avs_waitrequest;
    wire        is_mem = (a == `CCP_ENT_DATA);
    wire        is_inc = ({a[7:5], 5'h00} == `CCP_INC_BASE);
    wire [2:0]  iax    = a[4:2];
    wire        full   = (i_avs_byteenable == 4'hf);
    // table access waits for the fsm; increment waits for its slot
    wire        stall  = (is_mem & (st != S_IDLE))
                       | (is_inc & i_avs_write & pend[iax]
                          & (con_exp != 4'h0));
    wire        go     = req & ~stall & ~mrd_pend;
    wire        wr     = go & i_avs_write & full;
    wire        mem_rd = go & i_avs_read & is_mem;
    wire [31:0] d      = i_avs_writedata;

    // master position relative to the current cycle zero
    wire [31:0] mraw   = i_enc_pos[cam_master_select*32 +: 32]
                       - mbase;
    wire [31:0] cyc_m  = cyc_w[cam_master_select];

    // contour: segment starts when every selected axis has data
    wire        con_go = con_act & ~con_run & (|con_sel)
                       & (&(pend | ~con_sel));
    wire [8:0]  k1     = k + 9'h001;
    wire [8:0]  seg_len = 9'h001 << exp_cur;

    // cam interpolation on the shared divider
    wire [31:0] frac   = ($signed(mpos) < $signed(seg))
                       ? 32'h0 : mpos - seg;
    wire signed [63:0] prod = $signed(mem_q - t0) * $signed(frac);
    wire signed [63:0] quo  = prod / $signed({32'h0, width});
    wire [31:0] cam_val = t0 + quo[31:0];

    ////////////////////////////////////////////////////////////////////
    // table memory: bus owns it while the fsm is idle
    wire        mem_re = mem_rd | (st == S_RD0) | (st == S_RD1);
    wire [11:0] fsm_ad = (st == S_RD0) ? {idx, ax}
                       : {idx + 9'h001, ax};
    ccp_table_ram u_ram (
        .i_mclk  (i_mclk),
        .i_we    (wr & is_mem),
        .i_re    (mem_re),
        .i_addr  ((st == S_IDLE) ? ent_addr : fsm_ad),
        .i_wdata (d),
        .o_rdata (mem_q)
    );

    ////////////////////////////////////////////////////////////////////
    // millisecond enable from the 200 MHz clock
    always @(posedge i_mclk) begin
        if (i_rst || tick_cnt == TICK_CYCLES - 1) begin
            tick_cnt <= 32'h0;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
        tick <= ~i_rst & (tick_cnt == TICK_CYCLES - 1);
    end

    ////////////////////////////////////////////////////////////////////
    // bus slave: waitrequest low for exactly one edge per request
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h0;
            mrd_pend          <= 1'b0;
        end else if (mrd_pend) begin
            // table data arrived from the registered read port
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata    <= mem_q;
            mrd_pend          <= 1'b0;
        end else if (mem_rd) begin
            mrd_pend          <= 1'b1;
        end else if (go) begin
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata    <= 32'h0;
            if (i_avs_read) begin
                case (a)
                    `CCP_CTRL:     o_avs_readdata <=
                        {25'h0, cam_master_select, 3'h0,
                         cam_enable};
                    `CCP_INDEX:    o_avs_readdata <=
                        {23'h0, idx};
                    `CCP_WIDTH:    o_avs_readdata <= width;
                    `CCP_OFFSET:   o_avs_readdata <= offset;
                    `CCP_STATUS:   o_avs_readdata <=
                        {16'h0, dis_arm,
                         o_cam_engage_status};
                    `CCP_ENT_ADDR: o_avs_readdata <= {20'h0, ent_addr};
                    `CCP_AXIS_SEL: o_avs_readdata <= {29'h0, asel};
                    `CCP_CYCLE:    o_avs_readdata <=
                        cyc_w[asel];
                    `CCP_ENG_POS:  o_avs_readdata <= epos_w[asel];
                    `CCP_DIS_POS:  o_avs_readdata <= dpos_w[asel];
                    `CCP_CON_AXES: o_avs_readdata <= {24'h0, con_sel};
                    `CCP_CON_EXP:  o_avs_readdata <= {28'h0, con_exp};
                    `CCP_CON_STAT: o_avs_readdata <=
                        {22'h0, pend, con_run, con_act};
                    `CCP_MPOS:     o_avs_readdata <= mpos;
                    default: begin
                        // increments read back; others read zero
                        if (is_inc) begin
                            o_avs_readdata <=
                                {{16{inc_w[iax][15]}}, inc_w[iax]};
                        end
                    end
                endcase
            end
        end else begin
            o_avs_waitrequest <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // host-written configuration and contour control
    always @(posedge i_mclk) begin
        if (i_rst) begin
            cam_enable        <= 1'b0;
            cam_master_select <= 3'h0;
            ent_addr          <= 12'h0;
            asel              <= 3'h0;
            con_sel           <= 8'h0;
            con_exp           <= 4'h0;
            con_act           <= 1'b0;
        end else if (wr) begin
            case (a)
                `CCP_CTRL: begin
                    cam_enable        <= d[`CCP_CTRL_EN];
                    cam_master_select <= d[`CCP_MSEL_LSB +: 3];
                end
                `CCP_ENT_ADDR: ent_addr <= d[11:0];
                `CCP_AXIS_SEL: asel     <= d[2:0];
                `CCP_CON_AXES: begin
                    con_sel <= d[7:0];
                    con_act <= |d[7:0];
                end
                `CCP_CON_EXP: begin
                    // exponents above the top clamp to the top
                    con_exp <= (d[3:0] > `CCP_EXP_MAX)
                             ? `CCP_EXP_MAX : d[3:0];
                end
                default: begin
                    // zero exponent plus zero increment ends contour
                    if (is_inc && con_exp == 4'h0
                            && d[15:0] == 16'h0) begin
                        con_act <= 1'b0;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // contour segment stepping, one step per ms
    always @(posedge i_mclk) begin
        if (i_rst) begin
            con_run <= 1'b0;
            exp_cur <= 4'h1;
            k       <= 9'h0;
        end else if (con_go) begin
            con_run <= 1'b1;
            exp_cur <= con_exp;
            k       <= 9'h0;
        end else if (con_run && tick) begin
            k <= k1;
            if (k1 == seg_len) begin
                con_run <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // cam fsm: wrap master, seek interval, interpolate each axis
    always @(posedge i_mclk) begin
        if (i_rst) begin
            st        <= S_IDLE;
            ax        <= 3'h0;
            tick_pend <= 1'b0;
            idx       <= 9'h0;
            width     <= `CCP_WIDTH_RST;
            offset    <= `CCP_ZERO32;
            seg       <= `CCP_ZERO32;
            mbase     <= `CCP_ZERO32;
            mpos      <= `CCP_ZERO32;
            mprev     <= `CCP_ZERO32;
            t0        <= `CCP_ZERO32;
            chk       <= 1'b0;
        end else begin
            chk <= 1'b0;
            if (tick) begin
                tick_pend <= cam_enable;
            end
            case (st)
                S_IDLE: begin
                    // host index and spacing writes only land here
                    if (wr && a == `CCP_INDEX) begin
                        idx <= d[8:0];
                        seg <= offset + d[8:0] * width;
                    end else if (wr && a == `CCP_WIDTH) begin
                        width <= (d == 32'h0) ? 32'h1 : d;
                        idx   <= 9'h0;
                        seg   <= offset;
                    end else if (wr && a == `CCP_OFFSET) begin
                        offset <= d;
                        idx    <= 9'h0;
                        seg    <= d;
                    end else if (tick_pend && !mrd_pend && !mem_rd) begin
                        tick_pend <= tick & cam_enable;
                        st        <= S_MOD;
                    end
                end
                S_MOD: begin
                    // fold the master into one cycle, rezero at the end
                    if (cyc_m != 32'h0 && $signed(mraw) < 0) begin
                        mbase <= mbase - cyc_m;
                    end else if (cyc_m != 32'h0 && mraw >= cyc_m) begin
                        mbase <= mbase + cyc_m;
                        mprev <= 32'h0;
                        idx   <= 9'h0;
                        seg   <= offset;
                    end else begin
                        mprev <= mpos;
                        mpos  <= mraw;
                        st    <= S_SEEK;
                    end
                end
                S_SEEK: begin
                    // one interval per clock; at most 255 per pass
                    if (idx < `CCP_LAST_IDX - 9'h001
                            && mpos >= seg + width) begin
                        idx <= idx + 9'h001;
                        seg <= seg + width;
                    end else if (idx != 9'h0 && mpos < seg) begin
                        idx <= idx - 9'h001;
                        seg <= seg - width;
                    end else begin
                        chk <= 1'b1;
                        ax  <= 3'h0;
                        st  <= S_RD0;
                    end
                end
                S_RD0: st <= S_RD1;
                S_RD1: begin
                    t0 <= mem_q;
                    st <= S_RD2;
                end
                S_RD2: begin
                    ax <= ax + 3'h1;
                    st <= (ax == 3'h7) ? S_IDLE : S_RD0;
                end
                default: st <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per-axis state: cam engagement, contour data, command output
    genvar g;
    generate
        for (g = 0; g < `CCP_AXES; g = g + 1) begin : axis
            reg [31:0] cyc;      // master cycle length when this axis is master
            reg [31:0] epos;     // engage master position
            reg [31:0] dpos;     // disengage master position
            reg        arm_e;    // engage armed
            reg        arm_d;    // disengage armed
            reg        eng;      // slave cam-driven
            reg [15:0] inc;      // increment waiting
            reg [15:0] inc_cur;  // increment being stepped
            reg        pnd;      // increment waiting flag
            reg [31:0] base;     // position at segment start
            reg [31:0] pos;      // commanded position
            reg        vld;      // new command this cycle
            wire       sel_wr = wr && asel == g;
            wire       inc_wr = wr && is_inc && iax == g
                              && con_exp != 4'h0;
            wire [25:0] step  = $signed(inc_cur)
                              * $signed({1'b0, k1});
            wire [25:0] part  = $signed(step) >>> exp_cur;
            // a position outside the cycle acts at once
            wire       hit_e  = (epos >= cyc_m) || (epos == mpos)
                              || (epos > mprev && epos <= mpos);
            wire       hit_d  = (dpos >= cyc_m) || (dpos == mpos)
                              || (dpos > mprev && dpos <= mpos);

            // configuration writes and engage bookkeeping
            always @(posedge i_mclk) begin
                if (i_rst) begin
                    cyc   <= `CCP_ZERO32;
                    epos  <= `CCP_ZERO32;
                    dpos  <= `CCP_ZERO32;
                    arm_e <= 1'b0;
                    arm_d <= 1'b0;
                    eng   <= 1'b0;
                end else begin
                    if (sel_wr && a == `CCP_CYCLE) begin
                        cyc <= d;
                    end
                    if (!cam_enable || cam_master_select == g) begin
                        eng   <= 1'b0;
                        arm_e <= 1'b0;
                        arm_d <= 1'b0;
                    end else if (sel_wr && a == `CCP_ENG_POS) begin
                        epos  <= d;
                        arm_e <= 1'b1;
                    end else if (sel_wr && a == `CCP_DIS_POS) begin
                        dpos  <= d;
                        arm_d <= 1'b1;
                    end else if (chk) begin
                        if (arm_d && eng && hit_d) begin
                            eng   <= 1'b0;
                            arm_d <= 1'b0;
                        end else if (arm_e && hit_e) begin
                            eng   <= 1'b1;
                            arm_e <= 1'b0;
                        end
                    end
                end
            end

            // contour data slot and command position
            always @(posedge i_mclk) begin
                if (i_rst) begin
                    inc     <= 16'h0;
                    inc_cur <= 16'h0;
                    pnd     <= 1'b0;
                    base    <= `CCP_ZERO32;
                    pos     <= `CCP_ZERO32;
                    vld     <= 1'b0;
                end else begin
                    vld <= 1'b0;
                    if (!con_act) begin
                        pnd <= 1'b0;
                    end else if (inc_wr) begin
                        inc <= d[15:0];
                        pnd <= con_sel[g];
                    end else if (con_go) begin
                        pnd <= 1'b0;
                    end
                    if (con_go && con_sel[g]) begin
                        inc_cur <= inc;
                        base    <= pos;
                    end
                    if (st == S_RD2 && ax == g && eng) begin
                        pos <= cam_val;
                        vld <= 1'b1;
                    end else if (con_run && tick && con_sel[g]) begin
                        // scale from the segment start: no drift
                        pos <= base + {{6{part[25]}}, part};
                        vld <= 1'b1;
                    end
                end
            end

            assign cyc_w[g]  = cyc;
            assign epos_w[g] = epos;
            assign dpos_w[g] = dpos;
            assign inc_w[g]  = inc;
            assign pend[g]   = pnd;
            assign dis_arm[g] = arm_d;
            assign o_cmd_pos[g*32 +: 32]  = pos;
            assign o_cmd_valid[g]         = vld;
            assign o_cam_engage_status[g] = eng;
        end
    endgenerate
endmodule

// ### tb/ccp_monitor.sv
`timescale 1ns/1ps
module ccp_monitor (
    input wire         i_mclk,
    input wire         i_rst,
    input wire [7:0]   i_avs_address,
    input wire         i_avs_read,
    input wire         i_avs_write,
    input wire [31:0]  o_avs_readdata,
    input wire         o_avs_waitrequest,
    input wire [255:0] o_cmd_pos,
    input wire [7:0]   o_cmd_valid,
    input wire [7:0]   o_cam_engage_status
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    a_wait_one_cycle: assert property (!o_avs_waitrequest |=>
        o_avs_waitrequest) else $error("answer held over one cycle");
    a_no_request_wait: assert property (!i_avs_read && !i_avs_write
        |=> o_avs_waitrequest) else $error("answer without request");
    a_answer_bound: assert property ($rose(i_avs_read || i_avs_write)
        |-> ##[1:1000] !o_avs_waitrequest) else $error("bus hang");
    a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest
        && i_avs_address == 8'h3c |-> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_readdata_stands: assert property (o_avs_waitrequest
        && $past(o_avs_waitrequest) |-> $stable(o_avs_readdata))
        else $error("read data moved between answers");
    a_release_quiet: assert property ($fell(i_rst) |-> o_avs_waitrequest
        && o_cmd_valid == 8'h00 && o_cam_engage_status == 8'h00)
        else $error("outputs busy after reset");
    a_pos_has_pulse: assert property (o_cmd_pos != $past(o_cmd_pos)
        |-> o_cmd_valid != 8'h00) else $error("position moved silently");
    a_one_point_ms: assert property (o_cmd_valid[0] |=>
        (!o_cmd_valid[0]) [*8]) else $error("points too close");
    c_point: cover property (o_cmd_valid[0]);
    c_write: cover property (i_avs_write && !o_avs_waitrequest);
    c_read: cover property (i_avs_read && !o_avs_waitrequest);
endmodule
bind ccp_profiler ccp_monitor u_ccp_monitor (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_cmd_pos(o_cmd_pos),
    .o_cmd_valid(o_cmd_valid), .o_cam_engage_status(o_cam_engage_status));

// ### tb/ccp_servo_model.sv
`timescale 1ns/1ps
// servo loops: each axis encoder settles on its command one cycle later
module ccp_servo_model (
    input  wire         i_mclk,
    input  wire         i_rst,
    input  wire [255:0] i_cmd_pos,
    input  wire [7:0]   i_cmd_valid,
    output reg  [255:0] o_enc_pos
);
    integer n;
    always @(posedge i_mclk) begin
        for (n = 0; n < 8; n = n + 1) begin
            if (i_rst)
                o_enc_pos[32*n +: 32] <= 32'h0;
            else if (i_cmd_valid[n])
                o_enc_pos[32*n +: 32] <= i_cmd_pos[32*n +: 32];
        end
    end
endmodule

// ### tb/cam_and_contour_profiler_tb.sv
`timescale 1ns/1ps
module cam_and_contour_profiler_tb;
    reg          i_mclk = 1'b0;
    reg          i_rst = 1'b1;
    reg  [7:0]   i_avs_address = 8'h00;
    reg          i_avs_read = 1'b0;
    reg          i_avs_write = 1'b0;
    reg  [31:0]  i_avs_writedata = 32'h0;
    reg  [3:0]   i_avs_byteenable = 4'hf;
    wire [31:0]  o_avs_readdata;
    wire         o_avs_waitrequest;
    wire [255:0] enc_pos;
    wire [255:0] o_cmd_pos;
    wire [7:0]   o_cmd_valid;
    wire [7:0]   o_cam_engage_status;
    integer      failures = 0;
    integer      n_compared = 0;
    integer      cyc = 0;
    integer      i, k, t0;
    reg  [31:0]  q;
    reg  [71:0]  rows [0:11]; // address, write data, expected readback
    always #2.5 i_mclk = ~i_mclk;
    ccp_profiler #(.TICK_CYCLES(80)) u_ccp_profiler (.i_mclk(i_mclk),
        .i_rst(i_rst), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_enc_pos(enc_pos),
        .o_cmd_pos(o_cmd_pos), .o_cmd_valid(o_cmd_valid),
        .o_cam_engage_status(o_cam_engage_status));
    ccp_servo_model u_ccp_servo_model (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_cmd_pos(o_cmd_pos), .i_cmd_valid(o_cmd_valid),
        .o_enc_pos(enc_pos));
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    // request held until waitrequest is sampled low, released after
    task xfer(input w, input [7:0] a, input [31:0] d);
        begin
            i_avs_address <= a;
            i_avs_writedata <= d;
            i_avs_write <= w;
            i_avs_read <= !w;
            @(posedge i_mclk);
            while (o_avs_waitrequest !== 1'b0) @(posedge i_mclk);
            q = o_avs_readdata;
            i_avs_write <= 1'b0;
            i_avs_read <= 1'b0;
            @(posedge i_mclk);
        end
    endtask
    task close_out;
        begin
            $display("compared %0d failures %0d", n_compared, failures);
            if (failures == 0 && n_compared > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // hang guard: the run needs far fewer cycles
    always @(posedge i_mclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            close_out;
        end
    end
    initial begin
        rows[0] = {8'h00, 32'h21, 32'h21}; // enable, master axis 2
        rows[1] = {8'h00, 32'h20, 32'h20};
        rows[2] = {8'h08, 32'h190, 32'h190};
        rows[3] = {8'h08, 32'h0, 32'h1}; // zero width kept as one
        rows[4] = {8'h0c, 32'h0, 32'h0};
        rows[5] = {8'h04, 32'h5, 32'h5};
        rows[6] = {8'h1c, 32'h1, 32'h1};
        rows[7] = {8'h20, 32'h5dc, 32'h5dc};
        rows[8] = {8'h14, 32'h19, 32'h19};
        rows[9] = {8'h18, 32'hbb8, 32'hbb8};
        rows[10] = {8'h30, 32'h9, 32'h8}; // exponent clamps
        rows[11] = {8'h3c, 32'h5, 32'h0}; // unmapped
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        for (k = 0; k < 12; k = k + 1) begin
            xfer(1'b1, rows[k][71:64], rows[k][63:32]);
            xfer(1'b0, rows[k][71:64], 32'h0);
            check(q, rows[k][31:0]);
        end
        i_rst <= 1'b1; // second reset mid-run
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        xfer(1'b0, 8'h08, 32'h0);
        check(q, 32'h1);
        xfer(1'b0, 8'h10, 32'h0);
        check(q, 32'h0);
        i_avs_byteenable <= 4'h3; // partial write must be ignored
        xfer(1'b1, 8'h08, 32'h7);
        i_avs_byteenable <= 4'hf;
        xfer(1'b0, 8'h08, 32'h0);
        check(q, 32'h1);
        // contour: 48 counts over 4 ms on axis 0 only
        xfer(1'b1, 8'h30, 32'h2);
        xfer(1'b1, 8'h2c, 32'h1);
        xfer(1'b1, 8'h40, 32'h30);
        for (k = 1; k < 5; k = k + 1) begin
            @(posedge i_mclk);
            for (i = 0; i < 400 && o_cmd_valid[0] !== 1'b1; i = i + 1)
                @(posedge i_mclk);
            check(o_cmd_pos[31:0], 12 * k);
            check(o_cmd_pos[63:32], 32'h0);
            if (k > 1) check(cyc - t0, 80);
            t0 = cyc;
        end
        for (i = 0; i < 240; i = i + 1) begin
            @(posedge i_mclk);
            check({24'h0, o_cmd_valid}, 32'h0);
        end
        xfer(1'b0, 8'h34, 32'h0);
        check(q & 32'h1, 32'h1);
        xfer(1'b1, 8'h30, 32'h0);
        xfer(1'b1, 8'h40, 32'h0);
        xfer(1'b0, 8'h34, 32'h0);
        check(q & 32'h1, 32'h0);
        xfer(1'b1, 8'h18, 32'h7); // cam table points 0 and 1
        xfer(1'b1, 8'h14, 32'h8);
        xfer(1'b1, 8'h18, 32'h7);
        xfer(1'b1, 8'h00, 32'h11); // master axis 1
        xfer(1'b1, 8'h24, 32'h0);
        repeat (300) @(posedge i_mclk);
        check({24'h0, o_cam_engage_status}, 32'h1);
        check(o_cmd_pos[31:0], 32'h7);
        xfer(1'b1, 8'h28, 32'h0);
        repeat (300) @(posedge i_mclk);
        check({24'h0, o_cam_engage_status}, 32'h0);
        close_out;
    end
endmodule
